// [src/arbst_pkg.sv]
// Purpose: Shared constants for the arbiter status and reserve timer block.
// Assumes: Registers are reached through the pointer-addressed access port.
// Notes: Times are given in their own units; the package converts the millisecond to cycles.
package arbst_pkg;
    // Register pointer offsets.
    localparam logic [7:0] ARBST_OFS_STATUS = 8'h02;
    localparam logic [7:0] ARBST_OFS_RESERVE = 8'h03;
    // Reset values.
    localparam logic [7:0] ARBST_RST_STATUS = 8'h00;
    localparam logic [7:0] ARBST_RST_RESERVE = 8'h00;
    // Status field positions.
    localparam int ARBST_BIT_TEST = 5;
    localparam int ARBST_BIT_MAIL_IN = 4;
    localparam int ARBST_BIT_MAIL_OUT = 3;
    localparam int ARBST_BIT_HUNG = 2;
    localparam int ARBST_BIT_INIT_FAIL = 1;
    localparam int ARBST_BIT_OTHER_LOCK = 0;
    // Timing: system clock period and the millisecond tick.
    localparam int ARBST_CLK_PERIOD_NS = 8;
    localparam int ARBST_MS_TIME_NS = 1000000;
    localparam int ARBST_MS_CYCLES = ARBST_MS_TIME_NS / ARBST_CLK_PERIOD_NS;
    // Hung-bus interval in milliseconds.
    localparam int ARBST_HUNG_TIME_MS = 500;
endpackage

// [src/arbst_top.sv]
// Purpose: Per-master status and reserve-time logic of a two-master bus arbiter.
// Assumes: Register access arrives on the upstream link clock; arbitration decisions,
//          interrupt status and mailbox data live elsewhere on the system clock.
// Notes: One request at a time crosses from the link domain by a toggle handshake.
// Functional notes
// - Writing one to the self-test bit raises a self-test interrupt for that master.
// - Writing zero to the self-test bit does nothing; the bit reads as zero.
// - Self-test interrupt clears only by the master writing one to its status flag.
// - Pending unmasked self-test interrupt drives that master's interrupt output low.
// - Status bit 4 reads one while new mail from the other master waits.
// - Status bit 3 reads zero until the other master reads the sent mail.
// - Bit 2 sets when SDA low without SCL toggle, or SCL low, beyond 500 ms.
// - Bit 1 reads one when bus initialization fails with SDA still low.
// - Bit 0 reads one while the other master holds the bus lock.
// - Reserve time value counts milliseconds, 1 to 255.
// - Reserve time zero disables the timer; grant lasts until request clears.
// - Reserve time writes are ignored while that master holds the grant.
// - During a running reserve period the bus is never handed to the other master.
// - Reserve time resets to zero.
// - Clearing the lock request clears the grant and opens the bus switch.
// - Interrupt flags are sticky until the master writes one to them.
`timescale 1ns/1ps
`default_nettype none
module arbst_top #(
    parameter int MS_CYCLES = arbst_pkg::ARBST_MS_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic link_rst_n_in,
    input wire logic lk_req_in,
    input wire logic lk_wr_in,
    input wire logic lk_master_in,
    input wire logic [7:0] lk_addr_in,
    input wire logic [7:0] lk_wdata_in,
    output logic lk_busy_out,
    output logic lk_done_out,
    output logic [7:0] lk_rdata_out,
    input wire logic [1:0] lock_req_in,
    input wire logic [1:0] grant_pick_in,
    input wire logic [1:0] mail_sent_in,
    input wire logic [1:0] mail_taken_in,
    input wire logic [1:0] test_int_clr_in,
    input wire logic [1:0] test_int_mask_in,
    input wire logic init_done_in,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic [1:0] lock_grant_out,
    output logic switch_closed_out,
    output logic [1:0] int_n_out
);
    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
    localparam logic [9:0] HUNG_LIMIT = 10'(arbst_pkg::ARBST_HUNG_TIME_MS + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: capture one request and toggle it across.
    logic lk_tg_q;
    logic lk_wr_q;
    logic lk_mst_q;
    logic [7:0] lk_addr_q;
    logic [7:0] lk_wdata_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic lk_busy_q;
    logic ack_tg_q;
    logic [7:0] rdata_q;

    assign lk_busy_out = lk_tg_q != ack_s2_q;

    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tg_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // A request while busy is dropped; the caller waits for busy to fall.
    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            lk_tg_q <= 1'b0;
            lk_wr_q <= 1'b0;
            lk_mst_q <= 1'b0;
            lk_addr_q <= 8'h00;
            lk_wdata_q <= 8'h00;
        end else if (lk_req_in && !lk_busy_out) begin
            lk_tg_q <= ~lk_tg_q;
            lk_wr_q <= lk_wr_in;
            lk_mst_q <= lk_master_in;
            lk_addr_q <= lk_addr_in;
            lk_wdata_q <= lk_wdata_in;
        end
    end

    // Read data is stable in the system domain once the ack toggle arrives.
    always_ff @(posedge link_clk_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            lk_busy_q <= 1'b0;
            lk_done_out <= 1'b0;
            lk_rdata_out <= 8'h00;
        end else begin
            lk_busy_q <= lk_busy_out;
            lk_done_out <= lk_busy_q && !lk_busy_out;
            if (lk_busy_q && !lk_busy_out) begin
                lk_rdata_out <= rdata_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: synchronisers.
    logic req_s1_q;
    logic req_s2_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_d1_q;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_d1_q <= 1'b1;
        end else begin
            req_s1_q <= lk_tg_q;
            req_s2_q <= req_s1_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_d1_q <= scl_s2_q;
        end
    end

    logic acc_go;
    logic wr_status;
    logic wr_reserve;
    assign acc_go = req_s2_q != ack_tg_q;
    assign wr_status = acc_go && lk_wr_q && lk_addr_q == arbst_pkg::ARBST_OFS_STATUS;
    assign wr_reserve = acc_go && lk_wr_q && lk_addr_q == arbst_pkg::ARBST_OFS_RESERVE;

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond tick.
    logic [MSW-1:0] ms_cnt_q;
    logic ms_tick;
    assign ms_tick = ms_cnt_q == MS_LAST;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-master registers and flags.
    logic [7:0] reserve_time_q [2];
    logic [7:0] res_left_q [2];
    logic [1:0] res_en_q;
    logic [1:0] grant_q;
    logic [1:0] test_pend_q;
    logic [1:0] mail_pend_q;
    logic [1:0] mail_out_q;
    logic [1:0] expired;

    for (genvar i = 0; i < 2; i++) begin : g_mst
        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                reserve_time_q[i] <= arbst_pkg::ARBST_RST_RESERVE;
            end else if (wr_reserve && lk_mst_q == 1'(i) && !grant_q[i]) begin
                reserve_time_q[i] <= lk_wdata_q;
            end
        end

        // Set wins over a clear in the same cycle.
        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                test_pend_q[i] <= 1'b0;
            end else if (wr_status && lk_mst_q == 1'(i)
                         && lk_wdata_q[arbst_pkg::ARBST_BIT_TEST]) begin
                test_pend_q[i] <= 1'b1;
            end else if (test_int_clr_in[i]) begin
                test_pend_q[i] <= 1'b0;
            end
        end

        // Outgoing-consumed resets low and only rises once the other side takes mail.
        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                mail_pend_q[i] <= 1'b0;
                mail_out_q[i] <= 1'b0;
            end else begin
                mail_pend_q[i] <= mail_sent_in[1-i] || (mail_pend_q[i] && !mail_taken_in[i]);
                mail_out_q[i] <= mail_taken_in[1-i] || (mail_out_q[i] && !mail_sent_in[i]);
            end
        end
        assign expired[i] = res_en_q[i] && res_left_q[i] == 8'h00;

        // The arbiter proposes; a grant is held against any other proposal.
        always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                grant_q[i] <= 1'b0;
                res_left_q[i] <= 8'h00;
                res_en_q[i] <= 1'b0;
            end else if (grant_q[i]) begin
                if (!lock_req_in[i]) begin
                    grant_q[i] <= 1'b0;
                    res_en_q[i] <= 1'b0;
                end else if (expired[i] && lock_req_in[1-i]) begin
                    grant_q[i] <= 1'b0;
                    res_en_q[i] <= 1'b0;
                end else if (ms_tick && res_left_q[i] != 8'h00) begin
                    res_left_q[i] <= res_left_q[i] - 8'h01;
                end
            end else if (grant_q == 2'b00 && grant_pick_in[i] && lock_req_in[i]
                         && (i == 0 || !grant_pick_in[0])) begin
                grant_q[i] <= 1'b1;
                res_left_q[i] <= reserve_time_q[i];
                res_en_q[i] <= reserve_time_q[i] != 8'h00;
            end
        end

        assign int_n_out[i] = !(test_pend_q[i] && !test_int_mask_in[i]);
    end
    assign lock_grant_out = grant_q;
    assign switch_closed_out = |grant_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Downstream bus health.
    logic [9:0] hung_ms_q;
    logic hung_q;
    logic init_fail_q;

    // One counter covers both hang shapes: any SCL edge or an idle bus restarts it.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hung_ms_q <= 10'h000;
            hung_q <= 1'b0;
        end else begin
            if ((scl_s2_q != scl_d1_q) || (sda_s2_q && scl_s2_q)) begin
                hung_ms_q <= 10'h000;
                hung_q <= 1'b0;
            end else if (ms_tick && hung_ms_q != HUNG_LIMIT) begin
                hung_ms_q <= hung_ms_q + 10'h001;
            end else if (hung_ms_q == HUNG_LIMIT) begin
                hung_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            init_fail_q <= 1'b0;
        end else if (init_done_in) begin
            init_fail_q <= !sda_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path and acknowledge.
    logic [7:0] status_rd;
    always_comb begin
        status_rd = arbst_pkg::ARBST_RST_STATUS;
        status_rd[arbst_pkg::ARBST_BIT_MAIL_IN] = mail_pend_q[lk_mst_q];
        status_rd[arbst_pkg::ARBST_BIT_MAIL_OUT] = mail_out_q[lk_mst_q];
        status_rd[arbst_pkg::ARBST_BIT_HUNG] = hung_q;
        status_rd[arbst_pkg::ARBST_BIT_INIT_FAIL] = init_fail_q;
        status_rd[arbst_pkg::ARBST_BIT_OTHER_LOCK] = grant_q[!lk_mst_q];
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_tg_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (acc_go) begin
            ack_tg_q <= req_s2_q;
            if (lk_addr_q == arbst_pkg::ARBST_OFS_STATUS) begin
                rdata_q <= status_rd;
            end else if (lk_addr_q == arbst_pkg::ARBST_OFS_RESERVE) begin
                rdata_q <= reserve_time_q[lk_mst_q];
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    test_set_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        wr_status && lk_wdata_q[5] && !test_int_mask_in[lk_mst_q]
        |=> !int_n_out[$past(lk_mst_q)])
        else $error("Self-test write did not raise the interrupt.");
    test_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        wr_status && !lk_wdata_q[5] && !test_pend_q[lk_mst_q] && !test_int_clr_in[lk_mst_q]
        |=> !test_pend_q[$past(lk_mst_q)])
        else $error("Zero write changed the self-test state.");
    test_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        test_pend_q[0] && !test_int_clr_in[0] |=> test_pend_q[0])
        else $error("Self-test interrupt cleared without a clear.");
    int_pin_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        int_n_out[1] == !(test_pend_q[1] && !test_int_mask_in[1]))
        else $error("Interrupt output disagrees with pending and mask.");
    rsv_lock_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_q[0] ##1 grant_q[0] |-> $stable(reserve_time_q[0]))
        else $error("Reserve time changed while granted.");
    no_handover_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_q[0] && res_left_q[0] != 8'h00 && lock_req_in[0] |=> !grant_q[1])
        else $error("Bus handed over during reserve.");
    release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_q[1] && !lock_req_in[1] |=> !grant_q[1] ##0 !switch_closed_out || grant_q[0])
        else $error("Grant kept after request cleared.");
    expire_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_q[0] && expired[0] && lock_req_in[1] |=> !grant_q[0])
        else $error("Expired reserve did not end the grant.");
    tick_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ms_tick |=> !ms_tick ##0 ms_cnt_q == '0)
        else $error("Millisecond tick period broken.");
    other_lock_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        acc_go && lk_addr_q == arbst_pkg::ARBST_OFS_STATUS
        |=> rdata_q[0] == $past(grant_q[!lk_mst_q]))
        else $error("Other-lock bit wrong.");
    link_done_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n_in)
        lk_done_out |-> !lk_busy_out)
        else $error("Done while still busy.");

    grant_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(grant_q[0]));
    expire_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        grant_q[1] && expired[1] && lock_req_in[0]);
    test_c: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $fell(int_n_out[0]));
    done_c: cover property (@(posedge link_clk_in) disable iff (!link_rst_n_in) lk_done_out);
endmodule
`default_nettype wire

// [verification/arbst_link_master.sv]
// Purpose: Upstream master model that drives the register access port.
// Assumes: One access outstanding; the link clock runs free.
// Notes: Released address and write data show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module arbst_link_master (
    input wire logic link_clk_in,
    input wire logic busy_in,
    input wire logic done_in,
    input wire logic [7:0] rdata_in,
    output logic req_out,
    output logic wr_out,
    output logic master_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        req_out = 1'b0;
        wr_out = 1'b0;
        master_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // A request made while busy is dropped silently, so idle is awaited first.
    task automatic access(input logic w, input logic m, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        begin
            ok = 1'b0;
            q = 8'h00;
            for (n = 0; n < 20 && busy_in !== 1'b0; n++) begin
                @(posedge link_clk_in);
            end
            @(posedge link_clk_in);
            req_out <= 1'b1;
            wr_out <= w;
            master_out <= m;
            addr_out <= a;
            wdata_out <= d;
            @(posedge link_clk_in);
            req_out <= 1'b0;
            addr_out <= ~a;
            wdata_out <= ~d;
            for (n = 0; n < 12 && !ok; n++) begin
                @(posedge link_clk_in);
                if (done_in === 1'b1) begin
                    q = rdata_in;
                    ok = 1'b1;
                end
            end
        end
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Purpose: Self-checking bench for the status and reserve timer block.
// Assumes: The millisecond tick is shortened to 20 cycles.
// Notes: Expected status comes from state tracked in the bench.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int MS = 20;
    logic mclk_in = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] lock_req = 2'b00, pick = 2'b00, sent = 2'b00, taken = 2'b00;
    logic [1:0] clr = 2'b00, mask = 2'b00, grant, int_n, mi = 2'b00, mo = 2'b00;
    logic init_done = 1'b0, sda = 1'b1, scl = 1'b1, hung = 1'b0, fail = 1'b0;
    logic req, wr, mst, busy, done, sw, m;
    logic [7:0] addr, wdata, rdata, d;
    int miscompares = 0, check_count = 0, seed = 32'ha1da0b77;
    always #4 mclk_in = ~mclk_in;
    always #15 link_clk = ~link_clk;
    ////////////////////////////////////////////////////////////////////////////////
    arbst_top #(.MS_CYCLES(MS)) i_arbst_top (.mclk_in(mclk_in), .rst_n_in(rst_n),
        .link_clk_in(link_clk), .link_rst_n_in(rst_n), .lk_req_in(req), .lk_wr_in(wr),
        .lk_master_in(mst), .lk_addr_in(addr), .lk_wdata_in(wdata), .lk_busy_out(busy),
        .lk_done_out(done), .lk_rdata_out(rdata), .lock_req_in(lock_req),
        .grant_pick_in(pick), .mail_sent_in(sent), .mail_taken_in(taken),
        .test_int_clr_in(clr), .test_int_mask_in(mask), .init_done_in(init_done),
        .sda_in(sda), .scl_in(scl), .lock_grant_out(grant), .switch_closed_out(sw),
        .int_n_out(int_n));
    arbst_link_master i_arbst_link_master (.link_clk_in(link_clk), .busy_in(busy),
        .done_in(done), .rdata_in(rdata), .req_out(req), .wr_out(wr), .master_out(mst),
        .addr_out(addr), .wdata_out(wdata));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] stat(input logic s, input logic oth);
        return {3'b000, mi[s], mo[s], hung, fail, oth};
    endfunction
    task automatic complete_run;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic s, input logic [7:0] a,
                       input logic [7:0] v, input logic [7:0] e, input string nm);
        logic [7:0] q;
        logic ok;
        i_arbst_link_master.access(w, s, a, v, q, ok);
        check({nm, " ack"}, {7'h00, ok}, 8'h01);
        if (!w) check(nm, q, e);
    endtask
    task automatic tw(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic pulse(input int k, input logic [1:0] v);
        @(posedge mclk_in);
        case (k)
            0: sent <= v;
            1: taken <= v;
            2: clr <= v;
            default: init_done <= v[0];
        endcase
        @(posedge mclk_in);
        sent <= 2'b00;
        taken <= 2'b00;
        clr <= 2'b00;
        init_done <= 1'b0;
        tw(4);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        for (int s = 0; s < 2; s++) begin
            acc(0, s, arbst_pkg::ARBST_OFS_STATUS, 0, arbst_pkg::ARBST_RST_STATUS, "st0");
            acc(0, s, arbst_pkg::ARBST_OFS_RESERVE, 0, arbst_pkg::ARBST_RST_RESERVE, "rt0");
        end
        acc(1, 0, 8'h05, 8'hAA, 0, "unmapped");
        acc(0, 0, 8'h05, 0, 8'h00, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            m = 1'($random(seed));
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($random(seed));
            acc(1, m, arbst_pkg::ARBST_OFS_RESERVE, d, 0, "rt");
            acc(0, m, arbst_pkg::ARBST_OFS_RESERVE, 0, d, "rt");
        end
        $display("test reserve done");
        for (int s = 0; s < 2; s++) begin
            acc(1, s, arbst_pkg::ARBST_OFS_STATUS, 8'hDF, 0, "st");
            tw(4);
            check("int_n zero", {6'h00, int_n}, 8'h03);
            acc(1, s, arbst_pkg::ARBST_OFS_STATUS, 8'h20, 0, "st");
            tw(2);
            check("int_n set", {6'h00, int_n}, {6'h00, 2'b11 ^ (2'b01 << s)});
            acc(0, s, arbst_pkg::ARBST_OFS_STATUS, 0, stat(s, 0), "st test");
            @(posedge mclk_in);
            mask <= 2'b01 << s;
            tw(2);
            check("int_n masked", {6'h00, int_n}, 8'h03);
            @(posedge mclk_in);
            mask <= 2'b00;
            tw(2);
            check("int_n sticky", {6'h00, int_n}, {6'h00, 2'b11 ^ (2'b01 << s)});
            pulse(2, 2'b01 << s);
            check("int_n clr", {6'h00, int_n}, 8'h03);
        end
        $display("test self done");
        for (int k = 0; k < 3; k++) begin
            m = k[0];
            // The last round sends only after the earlier mail was consumed.
            pulse(0, 2'b01 << m);
            mi[~m] = 1'b1;
            mo[m] = 1'b0;
            acc(0, ~m, arbst_pkg::ARBST_OFS_STATUS, 0, stat(~m, 0), "mail in");
            acc(0, m, arbst_pkg::ARBST_OFS_STATUS, 0, stat(m, 0), "mail out");
            pulse(1, 2'b01 << ~m);
            mi[~m] = 1'b0;
            mo[m] = 1'b1;
            acc(0, ~m, arbst_pkg::ARBST_OFS_STATUS, 0, stat(~m, 0), "mail in");
            acc(0, m, arbst_pkg::ARBST_OFS_STATUS, 0, stat(m, 0), "mail out");
        end
        $display("test mail done");
        @(posedge mclk_in);
        sda <= 1'b0;
        tw(3);
        pulse(3, 2'b01);
        fail = 1'b1;
        acc(0, 0, arbst_pkg::ARBST_OFS_STATUS, 0, stat(0, 0), "init fail");
        @(posedge mclk_in);
        sda <= 1'b1;
        tw(3);
        pulse(3, 2'b01);
        fail = 1'b0;
        acc(0, 1, arbst_pkg::ARBST_OFS_STATUS, 0, stat(1, 0), "init ok");
        $display("test init done");
        @(posedge mclk_in);
        scl <= 1'b0;
        repeat (arbst_pkg::ARBST_HUNG_TIME_MS * MS - 100) @(posedge mclk_in);
        acc(0, 0, arbst_pkg::ARBST_OFS_STATUS, 0, stat(0, 0), "hung early");
        repeat (250) @(posedge mclk_in);
        hung = 1'b1;
        acc(0, 1, arbst_pkg::ARBST_OFS_STATUS, 0, stat(1, 0), "hung");
        @(posedge mclk_in);
        scl <= 1'b1;
        tw(5);
        hung = 1'b0;
        acc(0, 0, arbst_pkg::ARBST_OFS_STATUS, 0, stat(0, 0), "hung clear");
        $display("test hung done");
        acc(1, 0, arbst_pkg::ARBST_OFS_RESERVE, 8'h03, 0, "rt");
        acc(1, 1, arbst_pkg::ARBST_OFS_RESERVE, 8'h00, 0, "rt");
        @(posedge mclk_in);
        lock_req <= 2'b01;
        pick <= 2'b01;
        @(posedge mclk_in);
        lock_req <= 2'b11;
        pick <= 2'b10;
        tw(35);
        check("grant kept", {6'h00, grant}, 8'h01);
        tw(40);
        check("grant passed", {6'h00, grant}, 8'h02);
        @(posedge mclk_in);
        pick <= 2'b00;
        acc(0, 0, arbst_pkg::ARBST_OFS_STATUS, 0, stat(0, 1), "other lock");
        acc(0, 1, arbst_pkg::ARBST_OFS_STATUS, 0, stat(1, 0), "own lock");
        acc(1, 1, arbst_pkg::ARBST_OFS_RESERVE, 8'h55, 0, "rt locked");
        acc(0, 1, arbst_pkg::ARBST_OFS_RESERVE, 0, 8'h00, "rt locked");
        tw(300);
        check("grant open", {6'h00, grant}, 8'h02);
        @(posedge mclk_in);
        lock_req <= 2'b01;
        tw(3);
        check("grant drop", {6'h00, grant}, 8'h00);
        check("switch", {7'h00, sw}, 8'h00);
        @(posedge mclk_in);
        lock_req <= 2'b00;
        $display("test lock done");
        complete_run();
    end
endmodule
`default_nettype wire
